/* File: rtl/twm_ctrl.sv */
`timescale 1ns/100ps
module twm_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Chip state
	input wire logic hw_standby,
	input wire logic expanded_mode,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Interrupt request to CPU
	output logic irq_out
);
	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] ctrl_r, sar_r, data_r, shift_r;
	logic order_r, stall_r, ext_r;
	logic [2:0] bc_r;
	logic busy_r, irqf_r, al_r, aas_r, ackb_r, irq_armed_r;
	logic [31:0] hrdata_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic scl_q_r, sda_q_r;
	logic [3:0] bit_idx_r;
	logic first_byte_r, go_r, stalled_r;
	logic scl_low_r, gen_sda_low_r, sda_low_r;
	twm_pkg::twm_gen_e gen_r;

	logic if_en, master_select, transmit_select, ackm, acc, rd_acc;
	logic [7:0] wd, rd_mux, mode_rd, stat_rd;
	logic wr_ctrl, wr_stat, wr_data, wr_mode, wr_serial_timer_ctrl_reg, rd_data, rd_stat;
	logic sda_eff, rise, fall, start_det, stop_det;
	logic [3:0] data_bits, total_bits;
	logic in_ack, in_data, frame_run, frame_end, last_data_fall;
	logic [2:0] bit_sel;
	logic tx_bit, arb_lost, addr_match, stall_enter, start_req, stop_req;
	logic slave_ok, div_run, tick, sda_low_nxt;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ****************************************
	// Bus slave
	// ****************************************
	assign if_en = ctrl_r[twm_pkg::B_IF_EN];
	assign master_select = ctrl_r[twm_pkg::B_MST];
	assign transmit_select = ctrl_r[twm_pkg::B_TRS];
	assign ackm = ctrl_r[twm_pkg::B_ACKM];
	assign acc = hsel && htrans[1] && hready;
	assign rd_acc = acc && !hwrite;
	assign wd = hwdata[7:0];
	assign wr_ctrl = wr_pend_r && wr_addr_r == twm_pkg::OFS_CTRL;
	assign wr_stat = wr_pend_r && wr_addr_r == twm_pkg::OFS_STAT;
	assign wr_data = wr_pend_r && wr_addr_r == twm_pkg::OFS_DATA;
	assign wr_mode = wr_pend_r && wr_addr_r == twm_pkg::OFS_MODE;
	assign wr_serial_timer_ctrl_reg = wr_pend_r && wr_addr_r == twm_pkg::OFS_SERIAL_TIMER_CTRL_REG;
	assign rd_data = rd_acc && haddr[7:0] == twm_pkg::OFS_DATA;
	assign rd_stat = rd_acc && haddr[7:0] == twm_pkg::OFS_STAT;
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign mode_rd = {order_r, stall_r, twm_pkg::MODE_ONES, bc_r};
	assign stat_rd = {busy_r, irqf_r, twm_pkg::STAT_ONES, al_r, aas_r, 1'b0, ackb_r};

	always_comb begin
		case (haddr[7:0])
			twm_pkg::OFS_CTRL: rd_mux = ctrl_r;
			twm_pkg::OFS_STAT: rd_mux = stat_rd;
			twm_pkg::OFS_DATA: rd_mux = data_r;
			twm_pkg::OFS_MODE: rd_mux = if_en ? mode_rd : sar_r;
			twm_pkg::OFS_SERIAL_TIMER_CTRL_REG: rd_mux = {7'h00, ext_r};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data registered so it stands through the data phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_acc) begin
			hrdata_r <= {24'h00_0000, rd_mux};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc && hwrite;
			if (acc) begin
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= twm_pkg::CTRL_RST;
		end else if (hw_standby) begin
			ctrl_r <= twm_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wd;
			end
			if (addr_match) begin
				ctrl_r[twm_pkg::B_TRS] <= shift_r[0];
			end
			if (arb_lost) begin
				ctrl_r[twm_pkg::B_MST] <= 1'b0;
				ctrl_r[twm_pkg::B_TRS] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{order_r, stall_r, bc_r} <= {twm_pkg::MODE_RST[7:6], twm_pkg::MODE_RST[2:0]};
		end else if (hw_standby) begin
			{order_r, stall_r, bc_r} <= {twm_pkg::MODE_RST[7:6], twm_pkg::MODE_RST[2:0]};
		end else begin
			if (wr_mode && if_en) begin
				order_r <= wd[twm_pkg::B_ORDER];
				stall_r <= wd[twm_pkg::B_STALL];
				bc_r <= wd[2:0];
			end
			if (start_det || frame_end) begin
				bc_r <= twm_pkg::BC_RST;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sar_r <= twm_pkg::SAR_RST;
			ext_r <= 1'b0;
		end else if (hw_standby) begin
			sar_r <= twm_pkg::SAR_RST;
			ext_r <= 1'b0;
		end else begin
			if (wr_mode && !if_en) begin
				sar_r <= wd;
			end
			if (wr_serial_timer_ctrl_reg) begin
				ext_r <= wd[twm_pkg::B_EXT];
			end
		end
	end

	// Received bytes land here at frame end; in master transmit mode software writes start a transmit
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_r <= 8'h00;
		end else if (frame_end && !transmit_select) begin
			data_r <= shift_r;
		end else if (wr_data) begin
			data_r <= wd;
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irqf_r <= 1'b0;
			irq_armed_r <= 1'b0;
		end else if (hw_standby) begin
			irqf_r <= 1'b0;
			irq_armed_r <= 1'b0;
		end else begin
			if (rd_stat && irqf_r) begin
				irq_armed_r <= 1'b1;
			end
			// Set wins over a clear landing in the same cycle
			if (frame_end || arb_lost || stall_enter || addr_match) begin
				irqf_r <= 1'b1;
			end else if (wr_stat && !wd[twm_pkg::B_IRQF] && irq_armed_r) begin
				irqf_r <= 1'b0;
				irq_armed_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{busy_r, al_r, aas_r, ackb_r} <= 4'h0;
		end else if (hw_standby) begin
			{busy_r, al_r, aas_r, ackb_r} <= 4'h0;
		end else begin
			if (wr_stat) begin
				ackb_r <= wd[twm_pkg::B_ACKB];
				al_r <= al_r && wd[twm_pkg::B_AL];
				aas_r <= aas_r && wd[twm_pkg::B_AAS];
			end
			if (rise && in_ack && transmit_select && frame_run) begin
				ackb_r <= sda_eff;
			end
			if (start_det) begin
				busy_r <= 1'b1;
				aas_r <= 1'b0;
			end
			if (stop_det) begin
				busy_r <= 1'b0;
				aas_r <= 1'b0;
			end
			if (arb_lost) begin
				al_r <= 1'b1;
			end
			if (addr_match) begin
				aas_r <= 1'b1;
			end
		end
	end

	assign irq_out = irqf_r && ctrl_r[twm_pkg::B_IRQ_EN];

	// ****************************************
	// Line watch and frame counting
	// ****************************************
	assign sda_eff = expanded_mode ? 1'b1 : sda_in;
	assign rise = if_en && scl_in && !scl_q_r;
	assign fall = if_en && !scl_in && scl_q_r;
	assign start_det = if_en && scl_in && scl_q_r && sda_q_r && !sda_eff;
	assign stop_det = if_en && scl_in && scl_q_r && !sda_q_r && sda_eff;
	assign data_bits = (bc_r == twm_pkg::BC_RST) ? twm_pkg::BITS_FULL : {1'b0, bc_r};
	assign total_bits = data_bits + {3'h0, !ackm};
	assign in_data = bit_idx_r < data_bits;
	assign in_ack = !ackm && bit_idx_r == data_bits;
	assign bit_sel = order_r ? bit_idx_r[2:0] : twm_pkg::MSB_POS - bit_idx_r[2:0];
	assign tx_bit = data_r[bit_sel];
	assign slave_ok = aas_r || first_byte_r || sar_r[twm_pkg::B_FS];
	assign frame_run = busy_r && (master_select ? go_r : slave_ok);
	assign frame_end = fall && frame_run && bit_idx_r + 4'h1 == total_bits;
	assign last_data_fall = fall && frame_run && bit_idx_r + 4'h1 == data_bits;
	assign stall_enter = last_data_fall && !ackm && stall_r;
	assign arb_lost = rise && frame_run && master_select && transmit_select && in_data && tx_bit && !sda_eff;
	assign addr_match = frame_end && first_byte_r && !master_select && !sar_r[twm_pkg::B_FS]
		&& shift_r[7:1] == sar_r[7:1];

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_eff;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bit_idx_r <= 4'h0;
			shift_r <= 8'h00;
			first_byte_r <= 1'b0;
		end else if (!if_en || start_det || stop_det) begin
			bit_idx_r <= 4'h0;
			first_byte_r <= start_det;
		end else begin
			if (rise && frame_run && in_data && (!transmit_select || first_byte_r)) begin
				shift_r[bit_sel] <= sda_eff;
			end
			if (frame_end) begin
				bit_idx_r <= 4'h0;
				first_byte_r <= 1'b0;
			end else if (fall && frame_run) begin
				bit_idx_r <= bit_idx_r + 4'h1;
			end
		end
	end

	// Master frames are started by a data access, as in the host sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			go_r <= 1'b0;
		end else if (!if_en || !busy_r || frame_end || arb_lost) begin
			go_r <= 1'b0;
		end else if (master_select && (wr_data || rd_data)) begin
			go_r <= 1'b1;
		end
	end

	// SCL kept low from the last data fall until software clears the flag
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stalled_r <= 1'b0;
		end else if (!if_en || stop_det) begin
			stalled_r <= 1'b0;
		end else if (stall_enter) begin
			stalled_r <= 1'b1;
		end else if (!irqf_r) begin
			stalled_r <= 1'b0;
		end
	end

	// ****************************************
	// Master clock and conditions
	// ****************************************
	assign start_req = wr_stat && master_select && wd[twm_pkg::B_BUSY] && !wd[twm_pkg::B_SCP];
	assign stop_req = wr_stat && master_select && !wd[twm_pkg::B_BUSY] && !wd[twm_pkg::B_SCP];
	assign div_run = if_en && master_select && ((go_r && !stalled_r) || gen_r != twm_pkg::G_IDLE);

	twm_clk_div u_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(div_run),
		.ratio(twm_pkg::RATIO[{ext_r, ctrl_r[2:0]}]),
		.tick(tick)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gen_r <= twm_pkg::G_IDLE;
			scl_low_r <= 1'b0;
			gen_sda_low_r <= 1'b0;
		end else if (!if_en || !master_select) begin
			gen_r <= twm_pkg::G_IDLE;
			scl_low_r <= 1'b0;
			gen_sda_low_r <= 1'b0;
		end else begin
			case (gen_r)
				twm_pkg::G_IDLE: begin
					if (start_req) begin
						gen_r <= twm_pkg::G_START1;
						scl_low_r <= 1'b0;
					end else if (stop_req) begin
						gen_r <= twm_pkg::G_STOP1;
						gen_sda_low_r <= 1'b1;
					end else if (tick && go_r && !stalled_r) begin
						// A slow slave may stretch the low phase
						if (scl_low_r) begin
							scl_low_r <= 1'b0;
						end else if (scl_in) begin
							scl_low_r <= 1'b1;
						end
					end
				end
				twm_pkg::G_START1: begin
					if (tick && scl_in) begin
						gen_sda_low_r <= 1'b1;
						gen_r <= twm_pkg::G_START2;
					end
				end
				twm_pkg::G_START2: begin
					if (tick) begin
						scl_low_r <= 1'b1;
						gen_sda_low_r <= 1'b0;
						gen_r <= twm_pkg::G_IDLE;
					end
				end
				twm_pkg::G_STOP1: begin
					if (tick) begin
						scl_low_r <= 1'b0;
						gen_r <= twm_pkg::G_STOP2;
					end
				end
				twm_pkg::G_STOP2: begin
					if (tick && scl_in) begin
						gen_sda_low_r <= 1'b0;
						gen_r <= twm_pkg::G_IDLE;
					end
				end
				default: gen_r <= twm_pkg::G_IDLE;
			endcase
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	always_comb begin
		sda_low_nxt = 1'b0;
		if (gen_r != twm_pkg::G_IDLE) begin
			sda_low_nxt = gen_sda_low_r;
		end else if (frame_run && !arb_lost) begin
			if (transmit_select && in_data && !first_byte_r) begin
				sda_low_nxt = !tx_bit;
			end else if (master_select && transmit_select && in_data) begin
				sda_low_nxt = !tx_bit;
			end else if ((!transmit_select || (first_byte_r && !master_select)) && in_ack) begin
				sda_low_nxt = !ackb_r;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sda_low_r <= 1'b0;
		end else begin
			sda_low_r <= sda_low_nxt && if_en && !stop_det;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = !(if_en && (scl_low_r || stalled_r));
	assign sda_oe_n = !(if_en && !expanded_mode && sda_low_r);

	// ****************************************
	// Checks
	// ****************************************
	AST_MODE_ALIAS: assert property (rd_acc && haddr[7:0] == twm_pkg::OFS_MODE && !if_en
		|=> hrdata[7:0] == $past(sar_r)) else $error("shared address missed own id");
	AST_MODE_RST: assert property (hw_standby |=> order_r == 1'b0 && !stall_r
		&& bc_r == twm_pkg::BC_RST) else $error("mode register not reset");
	AST_STALL_HOLD: assert property (stalled_r && if_en |-> !scl_oe_n)
		else $error("stall released SCL");
	AST_NO_STALL: assert property (!stall_r && !stalled_r |=> !stalled_r)
		else $error("stall without stall field");
	AST_ONES: assert property (rd_acc && haddr[7:0] == twm_pkg::OFS_MODE && if_en
		|=> hrdata[5:3] == twm_pkg::MODE_ONES) else $error("fixed mode bits not one");
	AST_BC_CLR: assert property (start_det && !hw_standby |=> bc_r == twm_pkg::BC_RST)
		else $error("bit count kept over start");
	AST_CTRL_RST: assert property (hw_standby |=> ctrl_r == twm_pkg::CTRL_RST)
		else $error("control register not reset");
	AST_FLOAT: assert property (!if_en |-> scl_oe_n && sda_oe_n)
		else $error("pins driven while disabled");
	AST_EXP: assert property (expanded_mode |-> sda_oe_n)
		else $error("SDA driven in expanded mode");
	AST_IRQ_GATE: assert property (!ctrl_r[twm_pkg::B_IRQ_EN] |-> !irq_out)
		else $error("interrupt passed while disabled");
	AST_ARB: assert property (arb_lost && !hw_standby |=> !master_select && !transmit_select && al_r && irqf_r)
		else $error("arbitration loss not handled");
	AST_IDX: assert property (bit_idx_r <= total_bits || $changed(bc_r))
		else $error("bit index past frame");
	COV_FRAME: cover property (frame_end ##1 irqf_r);
	COV_ARB: cover property (arb_lost);
	COV_MATCH: cover property (addr_match ##1 aas_r);
	COV_STALL: cover property (stall_enter ##[1:50] !stalled_r);
endmodule

/* File: rtl/twm_pkg.sv */
package twm_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0C;
	localparam logic [7:0] OFS_SERIAL_TIMER_CTRL_REG = 8'h10;

	// ****************************************
	// Reset values and fixed read bits
	// ****************************************
	localparam logic [7:0] MODE_RST = 8'h38;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] SAR_RST = 8'h00;
	localparam logic [2:0] MODE_ONES = 3'h7;
	localparam logic [1:0] STAT_ONES = 2'h3;
	localparam logic [2:0] BC_RST = 3'h0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_IF_EN = 7;
	localparam int B_IRQ_EN = 6;
	localparam int B_MST = 5;
	localparam int B_TRS = 4;
	localparam int B_ACKM = 3;
	localparam int B_ORDER = 7;
	localparam int B_STALL = 6;
	localparam int B_BUSY = 7;
	localparam int B_IRQF = 6;
	localparam int B_SCP = 5;
	localparam int B_AL = 3;
	localparam int B_AAS = 2;
	localparam int B_ACKB = 0;
	localparam int B_FS = 0;
	localparam int B_EXT = 0;

	// ****************************************
	// Frame sizes and clock ratios
	// ****************************************
	localparam logic [3:0] BITS_FULL = 4'h8;
	localparam logic [2:0] MSB_POS = 3'h7;
	localparam logic [8:0] RATIO [0:15] = '{
		9'h01C, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080,
		9'h038, 9'h050, 9'h060, 9'h080, 9'h0A0, 9'h0C8, 9'h0E0, 9'h100
	};

	typedef enum logic [2:0] {
		G_IDLE, G_START1, G_START2, G_STOP1, G_STOP2
	} twm_gen_e;
endpackage

/* File: rtl/twm_clk_div.sv */
`timescale 1ns/100ps
module twm_clk_div (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic run,
	input wire logic [8:0] ratio,
	// Half-period enable pulse
	output logic tick
);
	logic [7:0] cnt_r;
	logic [7:0] half;
	logic tick_r;

	assign half = ratio[8:1];
	assign tick = tick_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
		end else if (!run || cnt_r == half - 8'h01) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// One half of the SCL period per pulse
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= run && cnt_r == half - 8'h01;
		end
	end

	AST_DIV_SPACING: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick |=> !tick) else $error("divider pulses back to back");
endmodule

/* File: tb/twm_bus_peer.sv */
`timescale 1ns/100ps
module twm_bus_peer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Device pin enables
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	// Behaviour control
	input wire logic stretch,
	input wire logic grab_sda,
	// Lines and observations
	output logic scl_line,
	output logic sda_line,
	output logic [15:0] cap,
	output logic [4:0] rises,
	output logic [9:0] period
);
	logic sda_low, scl_q, sda_q;
	logic [9:0] cyc;
	logic [5:0] hold;
	// Pulled-up open-drain lines
	assign scl_line = scl_oe_n & (hold == 6'h00);
	assign sda_line = sda_oe_n & ~sda_low;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_low <= 1'b0;
			hold <= 6'h00;
			cyc <= 10'h000;
			cap <= 16'h0000;
			rises <= 5'h00;
			period <= 10'h000;
		end else begin
			scl_q <= scl_line;
			sda_q <= sda_line;
			cyc <= cyc + 10'h001;
			if (scl_line && sda_q && !sda_line) begin
				rises <= 5'h00;
				cap <= 16'h0000;
			end else if (scl_line && !scl_q) begin
				rises <= rises + 5'h01;
				cap <= {cap[14:0], sda_line};
				cyc <= 10'h000;
				if (rises == 5'h02)
					period <= cyc + 10'h001;
			end
			// A slow peer stretches each low phase of SCL
			if (!scl_line && scl_q && stretch)
				hold <= 6'h28;
			else if (hold != 6'h00)
				hold <= hold - 6'h01;
			// Grabbing SDA only at a fall, so no false start is made
			if (!scl_line && scl_q)
				sda_low <= grab_sda;
			else if (!grab_sda)
				sda_low <= 1'b0;
		end
	end
endmodule

/* File: tb/test_twowire_mode_control_regs.sv */
`timescale 1ns/100ps
module test_twowire_mode_control_regs;
	// ****
	// Bench state
	// ****
	localparam logic [7:0] AC = twm_pkg::OFS_CTRL;
	localparam logic [7:0] AS = twm_pkg::OFS_STAT;
	localparam logic [7:0] AD = twm_pkg::OFS_DATA;
	localparam logic [7:0] AM = twm_pkg::OFS_MODE;
	localparam logic [7:0] AX = twm_pkg::OFS_SERIAL_TIMER_CTRL_REG;
	localparam logic [9:0] RT [0:15] = '{10'h01C, 10'h028, 10'h030, 10'h040,
		10'h050, 10'h064, 10'h070, 10'h080, 10'h038, 10'h050, 10'h060, 10'h080,
		10'h0A0, 10'h0C8, 10'h0E0, 10'h100};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic hw_standby = 1'b0;
	logic expanded_mode = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic stretch = 1'b0;
	logic grab = 1'b0;
	logic watch = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] lfsr = 32'h61EC;
	logic [31:0] r, hrdata;
	logic hreadyout, scl_line, sda_line, scl_oe_n, sda_oe_n, irq_out;
	logic [15:0] cap;
	logic [4:0] rises;
	logic [9:0] period;
	logic [7:0] rd;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	int sda_drv = 0;
	int scl_drv = 0;

	twm_ctrl i_twm_ctrl (.sys_clk(sys_clk), .resetn(resetn), .hw_standby(hw_standby),
		.expanded_mode(expanded_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .scl_in(scl_line),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(),
		.sda_oe_n(sda_oe_n), .irq_out(irq_out));
	twm_bus_peer i_twm_bus_peer (.sys_clk(sys_clk), .resetn(resetn),
		.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .stretch(stretch), .grab_sda(grab),
		.scl_line(scl_line), .sda_line(sda_line), .cap(cap), .rises(rises),
		.period(period));

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (watch && scl_oe_n !== 1'b1) scl_drv <= scl_drv + 1;
		if (watch && sda_oe_n !== 1'b1) sda_drv <= sda_drv + 1;
		if (cycles == 90000) begin
			fails = fails + 1;
			$display("ERROR %0t timeout", $time);
			stop_test();
		end
	end

	// ****
	// Tasks
	// ****
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp_r(input logic [7:0] got, input logic [7:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic cmp_l(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [4:0] nbits(input logic [7:0] m, input logic [7:0] c);
		return ((m[2:0] == 3'h0) ? 5'h08 : {2'h0, m[2:0]}) + {4'h0, ~c[3]};
	endfunction
	function automatic logic [15:0] ecap(input logic [7:0] m, input logic [7:0] c,
		input logic [7:0] d);
		logic [15:0] e;
		e = 16'h0000;
		for (int i = 0; i < ((m[2:0] == 3'h0) ? 8 : m[2:0]); i++)
			e = {e[14:0], m[7] ? d[i] : d[7 - i]};
		// Nobody acknowledges, so the released line reads high
		if (!c[3])
			e = {e[14:0], 1'b1};
		return e;
	endfunction
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata[7:0];
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
		bus(a, 1'b0, 8'h00);
		cmp_r(rd, e, m);
	endtask
	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		bus(AS, 1'b0, 8'h00);
		while (rd[b] !== v && k < 3000) begin
			bus(AS, 1'b0, 8'h00);
			k++;
		end
		if (k >= 3000) begin
			fails++;
			$display("ERROR %0t status poll ran out", $time);
		end
	endtask
	task automatic standby();
		@(posedge sys_clk);
		hw_standby <= 1'b1;
		@(posedge sys_clk);
		hw_standby <= 1'b0;
	endtask
	task automatic frame(input logic [7:0] c, input logic [7:0] m, input logic [7:0] d,
		input logic x);
		logic [4:0] n;
		logic [9:0] q;
		n = nbits(m, c);
		q = RT[{x, c[2:0]}];
		bus(AX, 1'b1, {7'h00, x});
		bus(AC, 1'b1, c);
		bus(AS, 1'b1, 8'h80);
		while (scl_line !== 1'b0) @(posedge sys_clk);
		bus(AM, 1'b1, m);
		bus(AD, 1'b1, d);
		poll(6, 1'b1);
		cmp_l({15'h0000, irq_out}, {15'h0000, c[6]}, "irq out");
		cmp_l({11'h000, rises}, {11'h000, n - {4'h0, m[6] & ~c[3]}}, "count");
		if (m[6] && !c[3]) begin
			repeat (100) @(posedge sys_clk);
			cmp_l({15'h0000, scl_line}, 16'h0000, "scl held");
			cmp_l({11'h000, rises}, {11'h000, n - 5'h01}, "held count");
			bus(AS, 1'b1, 8'hA0);
		end
		// Let the last bit close before looking at the line
		repeat (300) @(posedge sys_clk);
		cmp_l({11'h000, rises}, {11'h000, n}, "bits");
		cmp_l(cap & ((16'h0001 << n) - 16'h0001), ecap(m, c, d), "data");
		// A stalled acknowledge rise must not fall into the measured period
		if (!stretch && n - {4'h0, m[6] & ~c[3]} > 5'h02)
			cmp_l({15'h0000, period - q < 10'h004}, 16'h0001, "period");
		rdc(AM, {m[7:6], 6'h38}, "count cleared");
		bus(AS, 1'b0, 8'h00);
		bus(AS, 1'b1, 8'hA0);
		bus(AS, 1'b1, 8'h00);
		poll(7, 1'b0);
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		rdc(AC, 8'h00, "ctrl reset");
		rdc(AM, 8'h00, "id reset");
		bus(AM, 1'b1, 8'h5A);
		rdc(AM, 8'h5A, "id rw");
		rdc(8'h14, 8'h00, "unmapped");
		watch <= 1'b1;
		bus(AC, 1'b1, 8'h30);
		bus(AS, 1'b1, 8'h80);
		bus(AD, 1'b1, 8'hC3);
		repeat (500) @(posedge sys_clk);
		cmp_l(scl_drv[15:0], 16'h0000, "scl float");
		cmp_l(sda_drv[15:0], 16'h0000, "sda float");
		watch <= 1'b0;
		$display("test disabled done");
		bus(AC, 1'b1, 8'h80);
		rdc(AM, 8'h38, "mode reset");
		r = rnd();
		bus(AM, 1'b1, r[7:0] & 8'hF8);
		rdc(AM, {r[7:6], 6'h38}, "fixed ones");
		bus(AC, 1'b1, {1'b1, r[14:8]});
		rdc(AC, {1'b1, r[14:8]}, "ctrl rw");
		bus(AC, 1'b1, 8'h00);
		rdc(AM, 8'h5A, "id kept");
		standby();
		rdc(AC, 8'h00, "ctrl standby");
		bus(AC, 1'b1, 8'h80);
		rdc(AM, 8'h38, "mode standby");
		$display("test registers done");
		frame(8'hB0, 8'h38, 8'hA5, 1'b0);
		frame(8'hF8, 8'hB9, 8'h96, 1'b1);
		frame(8'hB7, 8'h78, 8'h3C, 1'b0);
		stretch <= 1'b1;
		frame(8'hB1, 8'h3D, 8'h5A, 1'b1);
		stretch <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			frame({1'b1, r[6], 2'h3, r[3:0]}, {r[15:14], 3'h7, r[18:16]}, r[31:24], r[20]);
		end
		$display("test frames done");
		bus(AC, 1'b1, 8'hB0);
		bus(AS, 1'b1, 8'h80);
		while (scl_line !== 1'b0) @(posedge sys_clk);
		grab <= 1'b1;
		bus(AD, 1'b1, 8'hFF);
		poll(6, 1'b1);
		grab <= 1'b0;
		rdc(AC, 8'h80, "lost arbitration");
		standby();
		$display("test arbitration done");
		expanded_mode <= 1'b1;
		watch <= 1'b1;
		bus(AC, 1'b1, 8'hB0);
		bus(AS, 1'b1, 8'h80);
		bus(AD, 1'b1, 8'h00);
		repeat (3000) @(posedge sys_clk);
		cmp_l(sda_drv[15:0], 16'h0000, "sda yields");
		watch <= 1'b0;
		expanded_mode <= 1'b0;
		standby();
		$display("test expanded done");
		stop_test();
	end
endmodule
